// ### hw/bors_pkg.sv
// Purpose: Shared constants and types for the brown-out reset sequencer.
// Assumes: 100 MHz system clock.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package bors_pkg;

    // Clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS      = 10;
    // Oscillator start-up length in oscillator periods.
    localparam int unsigned OSC_STARTUP_PERIODS = 1024;
    // Fail-safe monitor delay, longest figure, in microseconds.
    localparam int unsigned FAILSAFE_DELAY_US  = 900;
    localparam int unsigned FAILSAFE_CYCLES    = (FAILSAFE_DELAY_US * 1000) / CLK_PERIOD_NS;
    // One millisecond in clock cycles, base of the power-up delay.
    localparam int unsigned MS_NS              = 1000000;
    localparam int unsigned MS_CYCLES          = MS_NS / CLK_PERIOD_NS;
    // Timer widths.
    localparam int unsigned DLY_W              = 25;
    localparam int unsigned OST_W              = 11;

    // Register byte offsets.
    localparam logic [3:0] CFG_OFS   = 4'h0;
    localparam logic [3:0] CAUSE_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS  = 4'h8;

    // Configuration field positions.
    localparam int unsigned CFG_OSEL_LSB  = 0;
    localparam int unsigned CFG_PMODE_LSB = 4;
    localparam int unsigned CFG_POWERUP_TIMER_LSB  = 8;
    localparam int unsigned CFG_PLL_BIT   = 12;
    localparam int unsigned CFG_XTAL_BIT  = 13;
    localparam int unsigned CAUSE_BOR_BIT = 1;

    // Reset values.
    localparam logic [31:0] CFG_RST   = 32'h0000_0000;
    localparam logic [2:0]  PMODE_OFF = 3'h0;
    localparam logic [1:0]  PRIMARY_DISABLED = 2'h3;

    // Power-up delay codes: 0 none (fail-safe delay with crystal), then 2, 4, 16, 32, 64, 128 ms; 7 also 128 ms.
    localparam logic [2:0] POWERUP_TIMER_ZERO = 3'h0;

    // Sequencer states.
    typedef enum logic [2:0] {
        BORS_IDLE,
        BORS_PULSE,
        BORS_HOLD,
        BORS_DONE
    } bors_state_t;

    // Configuration image carried to the sequencer.
    typedef struct packed {
        logic       xtal;
        logic       pll;
        logic [2:0] powerup_timer_sel;
        logic [1:0] primary_osc_mode;
        logic [2:0] initial_osc_select;
    } bors_cfg_t;

endpackage

// ### hw/bors_timer.sv
// Purpose: Reloadable down-counter that flags expiry.
// Assumes: Synchronous active-low reset.
// Notes:   Used once, for the power-up delay; oscillator start-up has its own tick counter.
`timescale 1ns/1ns
module bors_timer #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              expired
);

    logic [W-1:0] cnt_q;
    logic         run_q;

    // A load restarts the count; expiry stays high until the next load.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= value;
            run_q <= 1'b1;
        end else if (run_q && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign expired = run_q && (cnt_q == '0) && !load;

endmodule

// ### hw/bors_top.sv
// Purpose: Brown-out reset sequencer with Avalon-MM register access.
// Assumes: Detector and oscillator status inputs are synchronous to CLK.
// Notes:   The reset cause register lives in an always-on domain.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
module bors_top
    import bors_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        BROWNOUT_DET,
    input  wire logic        SLEEP_MODE,
    input  wire logic        IDLE_MODE,
    input  wire logic        OSC_CLK_TICK,
    input  wire logic        PLL_LOCK,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             DEVICE_RESET,
    output logic             CLOCK_HOLD,
    output logic [2:0]       CLK_SRC_SEL,
    output logic [1:0]       PRIMARY_OSC_SEL,
    output logic             PLL_ENABLE
);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [31:0] cfg_q;
    logic        bor_flag_q;
    logic        bus_ack_q;
    logic [31:0] rdata_q;
    bors_cfg_t   cfg;
    wire         bus_req   = AVS_READ || AVS_WRITE;
    // Writes land only at the edge that accepts them, when waitrequest is low.
    wire         wr_cfg    = AVS_WRITE && bus_ack_q && AVS_ADDRESS == CFG_OFS;
    wire         wr_cause  = AVS_WRITE && bus_ack_q && AVS_ADDRESS == CAUSE_OFS;
    wire         clr_flag  = wr_cause && AVS_BYTEENABLE[0] && AVS_WRITEDATA[CAUSE_BOR_BIT];

    // One assignment feeds the whole configuration image, so it has one driver.
    assign cfg = '{xtal:               cfg_q[CFG_XTAL_BIT],
                   pll:                cfg_q[CFG_PLL_BIT],
                   powerup_timer_sel:           cfg_q[CFG_POWERUP_TIMER_LSB +: 3],
                   primary_osc_mode:   cfg_q[CFG_PMODE_LSB +: 2],
                   initial_osc_select: cfg_q[CFG_OSEL_LSB +: 3]};

    // Every access takes one wait cycle so read data come from a flip-flop.
    // The price is one extra cycle per access, which software never notices.
    assign AVS_WAITREQUEST = bus_req && !bus_ack_q;
    assign AVS_READDATA    = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    bors_state_t  state_q;
    bors_state_t  state_d;
    logic         ost_done_q;
    logic         dly_done_q;
    logic [DLY_W-1:0] dly_value;
    wire          osc_mode  = cfg.primary_osc_mode != PRIMARY_DISABLED;
    wire          ost_load  = state_q == BORS_PULSE;
    wire          dly_load  = state_q == BORS_PULSE;
    wire          ost_exp;
    wire          dly_exp;
    wire          clock_ok;
    wire          delay_ok;

    // The detector is watched in every power mode, Sleep and Idle included.
    wire          bor_event = BROWNOUT_DET;

    // Power-up delay selection in milliseconds, zero with crystal uses the monitor delay.
    always_comb begin
        case (cfg.powerup_timer_sel)
            3'h1:    dly_value = DLY_W'(2 * MS_CYCLES);
            3'h2:    dly_value = DLY_W'(4 * MS_CYCLES);
            3'h3:    dly_value = DLY_W'(16 * MS_CYCLES);
            3'h4:    dly_value = DLY_W'(32 * MS_CYCLES);
            3'h5:    dly_value = DLY_W'(64 * MS_CYCLES);
            3'h6:    dly_value = DLY_W'(128 * MS_CYCLES);
            3'h7:    dly_value = DLY_W'(128 * MS_CYCLES);
            default: dly_value = cfg.xtal ? DLY_W'(FAILSAFE_CYCLES) : '0;
        endcase
    end

    // Oscillator start-up counts oscillator ticks, not system clocks.
    logic [OST_W-1:0] ost_cnt_q;
    always_ff @(posedge CLK) begin
        if (!RST_N || ost_load) begin
            ost_cnt_q  <= '0;
            ost_done_q <= 1'b0;
        end else if (OSC_CLK_TICK && !ost_done_q) begin
            ost_cnt_q  <= ost_cnt_q + 1'b1;
            ost_done_q <= ost_cnt_q == OST_W'(OSC_STARTUP_PERIODS - 1);
        end
    end

    // Power-up delay counter, concurrent with the clock hold.
    bors_timer #(
        .W       (DLY_W)
    ) u_pwrup (
        .clk     (CLK),
        .rst_n   (RST_N),
        .load    (dly_load),
        .value   (dly_value),
        .expired (dly_exp)
    );
    assign ost_exp = ost_done_q;

    // Clock released after start-up timer when a primary oscillator is on and, with PLL, after lock.
    assign clock_ok = (!osc_mode || ost_exp) && (!cfg.pll || PLL_LOCK);
    assign delay_ok = dly_exp;

    // Next-state logic.
    always_comb begin
        state_d = state_q;
        case (state_q)
            BORS_IDLE:  if (bor_event) state_d = BORS_PULSE;
            BORS_PULSE: if (!bor_event) state_d = BORS_HOLD;
            BORS_HOLD: begin
                if (bor_event)
                    state_d = BORS_PULSE;
                else if (clock_ok && delay_ok)
                    state_d = BORS_IDLE;
            end
            default:    state_d = BORS_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= BORS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Reset stays asserted through the pulse, the hold and the delay.
    assign DEVICE_RESET = state_q != BORS_IDLE;
    assign CLOCK_HOLD   = (state_q == BORS_PULSE) || (state_q == BORS_HOLD && !clock_ok);
    assign CLK_SRC_SEL     = cfg.initial_osc_select;
    assign PRIMARY_OSC_SEL = cfg.primary_osc_mode;
    assign PLL_ENABLE      = cfg.pll;

    ////////////////////////////////////////////////////////////////////////////
    // Registers. The cause flag lives outside the device reset so it survives.

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg_q      <= CFG_RST;
            bor_flag_q <= 1'b0;
            bus_ack_q  <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end else begin
            bus_ack_q <= bus_req && !bus_ack_q;
            if (wr_cfg && AVS_BYTEENABLE[0])
                cfg_q[7:0] <= AVS_WRITEDATA[7:0];
            if (wr_cfg && AVS_BYTEENABLE[1])
                cfg_q[15:8] <= AVS_WRITEDATA[15:8];
            // A new brown-out wins over a software clear in the same cycle.
            if (ost_load)
                bor_flag_q <= 1'b1;
            else if (clr_flag)
                bor_flag_q <= 1'b0;
            if (AVS_READ && !bus_ack_q) begin
                case (AVS_ADDRESS)
                    CFG_OFS:   rdata_q <= {16'h0000, cfg_q[15:0]};
                    CAUSE_OFS: rdata_q <= {30'h0, bor_flag_q, 1'b0};
                    STAT_OFS:  rdata_q <= {27'h0, ost_exp, dly_exp, PLL_LOCK,
                                           CLOCK_HOLD, DEVICE_RESET};
                    default:   rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence bor_seen_s;
        bor_event && state_q == BORS_IDLE;
    endsequence

    property bor_resets_p;
        @(posedge CLK) disable iff (!RST_N) bor_seen_s |=> DEVICE_RESET && CLOCK_HOLD;
    endproperty
    bor_reset_pulse_a: assert property (bor_resets_p)
        else $error("Brown-out did not assert reset.");

    // The cause flag must follow the pulse on the very next edge.
    flag_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_PULSE |=> bor_flag_q)
        else $error("Brown-out flag not set.");

    flag_sticky_a: assert property (@(posedge CLK) disable iff (!RST_N)
        bor_flag_q && !clr_flag |=> bor_flag_q)
        else $error("Brown-out flag lost without a write.");

    pll_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_HOLD && cfg.pll && !PLL_LOCK |-> CLOCK_HOLD)
        else $error("Clock released before PLL lock.");

    ost_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_HOLD && osc_mode && !ost_done_q |-> CLOCK_HOLD)
        else $error("Clock released before start-up timer.");

    delay_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_HOLD && !dly_exp |=> DEVICE_RESET)
        else $error("Reset released before power-up delay.");

    sleep_bor_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (SLEEP_MODE || IDLE_MODE) && BROWNOUT_DET |=> DEVICE_RESET)
        else $error("Brown-out ignored in low-power mode.");

    src_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
        DEVICE_RESET |-> CLK_SRC_SEL == cfg_q[CFG_OSEL_LSB +: 3])
        else $error("Clock source not from configuration.");

    fscm_dly_a: assert property (@(posedge CLK) disable iff (!RST_N)
        cfg.powerup_timer_sel == POWERUP_TIMER_ZERO && cfg.xtal |-> dly_value == DLY_W'(FAILSAFE_CYCLES))
        else $error("Fail-safe delay not selected.");

    // Every release condition met while the detector is quiet.
    sequence hold_done_s;
        state_q == BORS_HOLD && clock_ok && delay_ok && !bor_event;
    endsequence

    // A fresh sag that arrives before the sequence has finished.
    sequence sag_again_s;
        state_q != BORS_IDLE && bor_event;
    endsequence

    // Reset must not linger once the delay and the clock are both done.
    reset_release_a: assert property (@(posedge CLK) disable iff (!RST_N)
        hold_done_s |=> !DEVICE_RESET)
        else $error("Reset held after the sequence was done.");

    // A sag during the sequence starts it over, so no delay is cut short.
    sag_restart_a: assert property (@(posedge CLK) disable iff (!RST_N)
        sag_again_s |=> state_q == BORS_PULSE)
        else $error("Repeated brown-out did not restart the sequence.");

    // The clock is freed as soon as its own conditions are met.
    clock_release_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_HOLD && clock_ok |-> !CLOCK_HOLD)
        else $error("Clock held after its conditions were met.");

    // Outside a sequence neither reset nor hold may show.
    idle_quiet_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_IDLE |-> !DEVICE_RESET && !CLOCK_HOLD)
        else $error("Reset or hold seen while idle.");

    // The pulse itself both resets the device and stops its clock.
    pulse_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_PULSE |-> DEVICE_RESET && CLOCK_HOLD)
        else $error("Pulse without reset and hold.");

    // Start-up is reported done only after the full count of ticks.
    ost_count_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(ost_done_q) |-> ost_cnt_q == OST_W'(OSC_STARTUP_PERIODS))
        else $error("Start-up timer expired early.");

    // Each pulse throws away a start-up count left from before.
    ost_restart_a: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == BORS_PULSE |=> !ost_done_q)
        else $error("Start-up timer not restarted.");

    // Without lock the clock conditions can never be met when the PLL is used.
    lock_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
        cfg.pll && !PLL_LOCK |-> !clock_ok)
        else $error("Clock allowed without PLL lock.");

    // A software clear outside a pulse empties the flag.
    flag_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        clr_flag && state_q != BORS_PULSE |=> !bor_flag_q)
        else $error("Brown-out flag not cleared by write.");

    // The oscillator mode seen by the clock tree follows the configuration.
    src_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
        DEVICE_RESET |-> PRIMARY_OSC_SEL == cfg_q[CFG_PMODE_LSB +: 2])
        else $error("Oscillator mode not from configuration.");

    // Shortest and longest power-up codes give their nominal lengths.
    powerup_timer_short_a: assert property (@(posedge CLK) disable iff (!RST_N)
        cfg.powerup_timer_sel == 3'h1 |-> dly_value == DLY_W'(2 * MS_CYCLES))
        else $error("Shortest power-up delay wrong.");

    powerup_timer_long_a: assert property (@(posedge CLK) disable iff (!RST_N)
        cfg.powerup_timer_sel == 3'h6 |-> dly_value == DLY_W'(128 * MS_CYCLES))
        else $error("Longest power-up delay wrong.");

    // A write may only land in the cycle in which the bus accepts it.
    write_accept_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_cfg || wr_cause) |-> !AVS_WAITREQUEST)
        else $error("Write landed while waitrequest was high.");

    // Exactly one wait cycle per access, so the acknowledge never stands twice.
    ack_single_a: assert property (@(posedge CLK) disable iff (!RST_N)
        bus_ack_q |=> !bus_ack_q)
        else $error("Bus acknowledge stood for two cycles.");

endmodule

// ### bench/bors_partner.sv
// Purpose: Stand-in for the supply detector, oscillator and PLL.
// Assumes: The bench raises brown for as long as the supply sags.
// Notes:   Lock is lost on every sag, as a real PLL would be reset.
`timescale 1ns/1ns
module bors_partner (
    input  wire logic clk,
    input  wire logic brown,
    input  wire logic slow,
    input  wire logic pll_ok,
    output logic      det  = 1'b0,
    output logic      tick = 1'b0,
    output logic      lock = 1'b0
);
    logic ph_q = 1'b0;

    // A slow oscillator ticks on every other cycle, a fast one on each.
    always @(posedge clk) begin
        ph_q <= ~ph_q;
        det  <= brown;
        tick <= ~slow | ph_q;
        lock <= pll_ok & ~brown;
    end
endmodule

// ### bench/bors_top_test.sv
// Purpose: Self-checking bench for the brown-out reset sequencer.
// Assumes: The partner model stands in for the analog side.
// Notes:   Power-up codes 1 to 7 last milliseconds and are left out.
`timescale 1ns/1ns
module bors_top_test;
    import bors_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        brown = 1'b0;
    logic        slow = 1'b0;
    logic        pll_ok = 1'b1;
    logic        sleep = 1'b0;
    logic        idle = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, cfg, r;
    logic        det, tick, lock, wait_r, dev_rst, hold, pll_en;
    logic [2:0]  src;
    logic [1:0]  posc;
    logic [31:0] expq[$];
    int          miscompares = 0;
    int          checks = 0;
    int          seed = 32'h07eb;

    always #5 clk = ~clk;

    bors_partner PARTNER (.clk(clk), .brown(brown), .slow(slow), .pll_ok(pll_ok),
                          .det(det), .tick(tick), .lock(lock));
    bors_top DUT (.CLK(clk), .RST_N(rst_n), .BROWNOUT_DET(det), .SLEEP_MODE(sleep),
                  .IDLE_MODE(idle), .OSC_CLK_TICK(tick), .PLL_LOCK(lock),
                  .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
                  .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
                  .AVS_WAITREQUEST(wait_r), .DEVICE_RESET(dev_rst), .CLOCK_HOLD(hold),
                  .CLK_SRC_SEL(src), .PRIMARY_OSC_SEL(posc), .PLL_ENABLE(pll_en));

    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request stands until the rising edge at which waitrequest is seen low.
    task automatic bus(input logic r_n, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= r_n;
        wr <= ~r_n;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 100);
        if (n >= 100) miscompares++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask

    task automatic until_low(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b0 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        compare({31'h0, s}, 32'h0);
    endtask

    // The sag is held for len plus 3 cycles; reset and hold are checked 3 cycles after it starts.
    task automatic brownout(input int len);
        @(posedge clk);
        brown <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        compare({30'h0, dev_rst, hold}, 32'h3);
        repeat (len) @(posedge clk);
        brown <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read results are judged at the rising edge at which the master takes them.
    always @(posedge clk) begin
        if (rd === 1'b1 && wait_r === 1'b0) begin
            if (expq.size() == 0) miscompares++;
            else compare(rdata, expq.pop_front());
        end
    end

    // The tests need about 94,000 cycles; a hang ends the run a little later.
    initial begin
        #990000;
        miscompares++;
        results;
    end

    // Pass 0 is a fast oscillator, pass 1 a slow one behind a late PLL.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(CFG_OFS, CFG_RST);
        rd_chk(CAUSE_OFS, 32'h0);
        rd_chk(4'hc, 32'h0);
        for (int i = 0; i < 2; i++) begin
            r = $random(seed);
            cfg = (r & 32'h27) | (i << CFG_PLL_BIT);
            slow <= i[0];
            pll_ok <= ~i[0];
            sleep <= i[0];
            idle <= ~i[0];
            bus(1'b0, CFG_OFS, cfg);
            rd_chk(CFG_OFS, cfg);
            compare({26'h0, src, posc, pll_en}, {26'h0, cfg[2:0], cfg[5:4], cfg[12]});
            brownout(4);
            repeat (1000) @(posedge clk);
            #1;
            compare({30'h0, dev_rst, hold}, 32'h3);
            if (i == 1) begin
                repeat (1200) @(posedge clk);
                #1;
                compare({31'h0, hold}, 32'h1);
                @(posedge clk);
                pll_ok <= 1'b1;
            end
            until_low(hold, 300);
            until_low(dev_rst, 20);
            rd_chk(STAT_OFS, 32'h1c);
            rd_chk(CAUSE_OFS, 32'h2);
            bus(1'b0, CAUSE_OFS, 32'h2);
            rd_chk(CAUSE_OFS, 32'h0);
        end
        // With no primary oscillator the clock is freed once the sag is gone.
        bus(1'b0, CFG_OFS, 32'h3 << CFG_PMODE_LSB);
        brownout(2);
        until_low(hold, 5);
        until_low(dev_rst, 5);
        bus(1'b0, CAUSE_OFS, 32'h2);
        // A crystal with no power-up code waits out only the fail-safe delay.
        bus(1'b0, CFG_OFS, 32'h1 << CFG_XTAL_BIT);
        brownout(2);
        repeat (FAILSAFE_CYCLES - 5000) @(posedge clk);
        #1;
        compare({31'h0, dev_rst}, 32'h1);
        until_low(dev_rst, 10000);
        results;
    end
endmodule
